// [include/lmtc_pkg.sv]
// Shared constants and types of the link mode and termination configuration block.
`default_nettype none
package lmtc_pkg;
  localparam int unsigned LMTC_LINKS         = 4;
  localparam int unsigned LMTC_ADDR_W        = 10;
  localparam logic [7:0]  LMTC_OFS_MODE      = 8'h20;
  localparam logic [7:0]  LMTC_OFS_TERM      = 8'h32;
  localparam logic [7:0]  LMTC_OFS_LINE      = 8'h33;
  localparam int unsigned LMTC_BIT_FMT_LO    = 0;
  localparam int unsigned LMTC_BIT_FMT_HI    = 1;
  localparam int unsigned LMTC_BIT_REGIONAL  = 2;
  localparam int unsigned LMTC_BIT_CARRIER   = 3;
  localparam int unsigned LMTC_BIT_TERM_EXT  = 2;
  localparam int unsigned LMTC_BIT_AMI       = 0;
  localparam int unsigned LMTC_BIT_RJA       = 1;
  localparam int unsigned LMTC_BIT_BPV       = 2;
  localparam logic [7:0]  LMTC_MASK_MODE     = 8'h0f;
  localparam logic [7:0]  LMTC_MASK_TERM     = 8'h07;
  localparam logic [7:0]  LMTC_MASK_LINE     = 8'h03;
  localparam logic [7:0]  LMTC_RST_MODE      = 8'h00;
  localparam logic [7:0]  LMTC_RST_TERM      = 8'h00;
  localparam logic [7:0]  LMTC_RST_LINE      = 8'h00;
  localparam logic [4:0]  LMTC_SPI_CMD_BITS  = 5'h10;
  localparam logic [4:0]  LMTC_SPI_ALL_BITS  = 5'h18;
  localparam int unsigned LMTC_SPI_READ_BIT  = 15;

  typedef enum logic [1:0] {LMTC_SEL_MODE, LMTC_SEL_TERM, LMTC_SEL_LINE, LMTC_SEL_NONE} lmtc_sel_type;
  typedef enum logic [1:0] {LMTC_MODE_E1, LMTC_MODE_T1, LMTC_MODE_J1, LMTC_MODE_RSVD} lmtc_mode_type;
  typedef enum logic [1:0] {LMTC_FRM_SF, LMTC_FRM_ESF, LMTC_FRM_DM, LMTC_FRM_SLC96} lmtc_frame_type;
  typedef enum logic [1:0] {LMTC_CODE_AMI, LMTC_CODE_B8ZS, LMTC_CODE_HDB3} lmtc_code_type;
  typedef enum logic [2:0] {LMTC_IMP_75, LMTC_IMP_120, LMTC_IMP_100, LMTC_IMP_110, LMTC_IMP_EXT} lmtc_imp_type;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [1:0]   link;
    lmtc_sel_type sel;
    logic [7:0]   wdata;
  } lmtc_req_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] term;
    logic [7:0] line;
  } lmtc_link_regs_type;

  typedef struct packed {
    lmtc_mode_type  mode;
    lmtc_frame_type frame;
    logic           int_match;
    lmtc_imp_type   imp;
    lmtc_code_type  rx_code;
    lmtc_code_type  tx_code;
    logic           rja_en;
    logic           bpv_ok;
  } lmtc_link_cfg_type;
endpackage
`default_nettype wire

// [logic/lmtc_cfg_store.sv]
// Per-link configuration register storage with registered read data.
`timescale 1ns/10ps
`default_nettype none
module lmtc_cfg_store (
  // Clock and reset.
  input  wire logic                                                clk_i,
  input  wire logic                                                rst_n_i,
  // Decoded register request.
  input  wire lmtc_pkg::lmtc_req_type                              req_i,
  // Read data and stored registers.
  output logic [7:0]                                               rdata_o,
  output lmtc_pkg::lmtc_link_regs_type [lmtc_pkg::LMTC_LINKS-1:0]  regs_o
);
  import lmtc_pkg::*;

  typedef struct packed {
    lmtc_link_regs_type [LMTC_LINKS-1:0] regs;
    logic [7:0]                          rdata;
  } lmtc_store_type;

  lmtc_store_type st_reg;
  lmtc_store_type st_next;

  always_comb begin
    st_next = st_reg;
    if (req_i.wr) begin
      case (req_i.sel)
        LMTC_SEL_MODE: st_next.regs[req_i.link].mode = req_i.wdata & LMTC_MASK_MODE;
        LMTC_SEL_TERM: st_next.regs[req_i.link].term = req_i.wdata & LMTC_MASK_TERM;
        LMTC_SEL_LINE: st_next.regs[req_i.link].line = req_i.wdata & LMTC_MASK_LINE;
        default:       st_next.regs = st_reg.regs;
      endcase
    end
    if (req_i.rd) begin
      case (req_i.sel)
        LMTC_SEL_MODE: st_next.rdata = st_reg.regs[req_i.link].mode;
        LMTC_SEL_TERM: st_next.rdata = st_reg.regs[req_i.link].term;
        LMTC_SEL_LINE: st_next.rdata = st_reg.regs[req_i.link].line;
        default:       st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{regs: {LMTC_LINKS{LMTC_RST_MODE, LMTC_RST_TERM, LMTC_RST_LINE}}, rdata: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign regs_o  = st_reg.regs;
endmodule // lmtc_cfg_store
`default_nettype wire

// [logic/lmtc_config_top.sv]
// Host ports, address decode and per-link mode and termination decode.
`timescale 1ns/10ps
`default_nettype none
//Contract
// RULE1: Configuration is accepted on either the SPI port or the parallel port, whichever the host uses.
// RULE2: Carrier family 0 makes a link E1 and its regional and format selections are ignored, per link.
// RULE3: Carrier family 1 with regional 0 is T1, with format 00 SF, 01 ESF, 10 DM and 11 SLC-96.
// RULE4: Carrier family 1 with regional 1 is J1 and offers only SF (00) and ESF (01).
// RULE5: A termination top bit of 0 turns the internal receive matching on.
// RULE6: With internal matching, code 000 is 75, 001 is 120, 010 is 100 and 011 is 110 ohm.
// RULE7: A termination top bit of 1 turns internal matching off whatever the low bits hold.
// RULE8: The receive decoder uses AMI, or B8ZS for T1 and J1, or HDB3 for E1.
// RULE9: The transmit encoder uses AMI or B8ZS for T1 and J1, and HDB3 for E1; the code copies rx_code into tx_code, so E1 also transmits AMI.
// RULE10: A diagnostic bipolar violation is inserted only while AMI is selected.
// RULE11: The receive jitter attenuator is chosen on or off per link.
// RULE12: Carrier 1, regional 1 with format 10 or 11 is reserved and decodes to no valid mode.
module lmtc_config_top (
  // Clock and reset.
  input  wire logic                                                clk_i,
  input  wire logic                                                rst_n_i,
  // Parallel microprocessor port.
  input  wire logic [lmtc_pkg::LMTC_ADDR_W-1:0]                    up_addr_i,
  input  wire logic [7:0]                                          up_wdata_i,
  input  wire logic                                                up_wr_i,
  input  wire logic                                                up_rd_i,
  output logic [7:0]                                               up_rdata_o,
  output logic                                                     up_rvalid_o,
  // SPI port.
  input  wire logic                                                spi_sclk_i,
  input  wire logic                                                spi_cs_n_i,
  input  wire logic                                                spi_sdi_i,
  output logic                                                     spi_sdo_o,
  output logic                                                     spi_sdo_oe_o,
  // Per-link configuration.
  output lmtc_pkg::lmtc_link_cfg_type [lmtc_pkg::LMTC_LINKS-1:0]   link_cfg_o,
  output logic [lmtc_pkg::LMTC_LINKS-1:0]                          bpv_insert_o
);
  import lmtc_pkg::*;

  typedef struct packed {
    logic                               sclk_q;
    logic                               cs_n_q;
    logic [4:0]                         bit_cnt;
    logic [15:0]                        cmd_sh;
    logic [7:0]                         data_sh;
    logic [7:0]                         sdo_sh;
    logic                               sdo_oe;
    logic                               spi_pend;
    lmtc_req_type                       spi_req;
    logic                               spi_rd_wait;
    logic                               up_rd_wait;
    logic [7:0]                         up_rdata;
    logic                               up_rvalid;
    logic [LMTC_LINKS-1:0]              bpv;
    lmtc_link_cfg_type [LMTC_LINKS-1:0] cfg;
  } lmtc_ctl_type;

  lmtc_ctl_type                         st_reg;
  lmtc_ctl_type                         st_next;
  lmtc_req_type                         req;
  logic [7:0]                           store_rdata;
  lmtc_link_regs_type [LMTC_LINKS-1:0]  regs;
  lmtc_link_cfg_type [LMTC_LINKS-1:0]   dec;
  logic                                 sclk_rise;
  logic                                 sclk_fall;

  function automatic lmtc_req_type lmtc_make_req(input logic wr, input logic rd,
                                                 input logic [LMTC_ADDR_W-1:0] addr, input logic [7:0] wdata);
    lmtc_req_type r;
    begin
      r.wr    = wr;
      r.rd    = rd;
      r.link  = addr[9:8];
      r.wdata = wdata;
      case (addr[7:0])
        LMTC_OFS_MODE: r.sel = LMTC_SEL_MODE;
        LMTC_OFS_TERM: r.sel = LMTC_SEL_TERM;
        LMTC_OFS_LINE: r.sel = LMTC_SEL_LINE;
        default:       r.sel = LMTC_SEL_NONE;
      endcase
      return r;
    end
  endfunction

  function automatic lmtc_link_cfg_type lmtc_decode(input lmtc_link_regs_type r);
    lmtc_link_cfg_type c;
    logic              carrier;
    logic              regional;
    logic [1:0]        fmt;
    begin
      carrier  = r.mode[LMTC_BIT_CARRIER];
      regional = r.mode[LMTC_BIT_REGIONAL];
      fmt      = r.mode[LMTC_BIT_FMT_HI:LMTC_BIT_FMT_LO];
      c        = '0;
      if (!carrier) begin
        c.mode  = LMTC_MODE_E1; // [RULE2]
        c.frame = LMTC_FRM_SF;
      end else if (!regional) begin
        c.mode  = LMTC_MODE_T1; // [RULE3]
        c.frame = lmtc_frame_type'(fmt);
      end else if (!fmt[1]) begin
        c.mode  = LMTC_MODE_J1; // [RULE4]
        c.frame = lmtc_frame_type'(fmt);
      end else begin
        c.mode  = LMTC_MODE_RSVD; // [RULE12]
        c.frame = LMTC_FRM_SF;
      end
      c.int_match = !r.term[LMTC_BIT_TERM_EXT]; // [RULE5] [RULE7]
      if (r.term[LMTC_BIT_TERM_EXT]) begin
        c.imp = LMTC_IMP_EXT; // [RULE7]
      end else begin
        case (r.term[1:0]) // [RULE6]
          2'h0:    c.imp = LMTC_IMP_75;
          2'h1:    c.imp = LMTC_IMP_120;
          2'h2:    c.imp = LMTC_IMP_100;
          default: c.imp = LMTC_IMP_110;
        endcase
      end
      if (r.line[LMTC_BIT_AMI]) begin
        c.rx_code = LMTC_CODE_AMI; // [RULE8]
      end else if (!carrier) begin
        c.rx_code = LMTC_CODE_HDB3; // [RULE8]
      end else begin
        c.rx_code = LMTC_CODE_B8ZS; // [RULE8]
      end
      c.tx_code = c.rx_code; // [RULE9]
      c.rja_en  = r.line[LMTC_BIT_RJA]; // [RULE11]
      c.bpv_ok  = r.line[LMTC_BIT_AMI]; // [RULE10]
      return c;
    end
  endfunction

  for (genvar g = 0; g < LMTC_LINKS; g++) begin : g_link
    assign dec[g] = lmtc_decode(regs[g]); // [RULE2]
  end

  assign sclk_rise = spi_sclk_i & ~st_reg.sclk_q & ~spi_cs_n_i;
  assign sclk_fall = ~spi_sclk_i & st_reg.sclk_q & ~spi_cs_n_i;

  always_comb begin
    st_next             = st_reg;
    st_next.sclk_q      = spi_sclk_i;
    st_next.cs_n_q      = spi_cs_n_i;
    st_next.up_rvalid   = 1'b0;
    st_next.bpv         = '0;
    st_next.cfg         = dec;
    st_next.up_rd_wait  = 1'b0;
    st_next.spi_rd_wait = 1'b0;
    req                 = '0;
    if (up_wr_i || up_rd_i) begin
      req                = lmtc_make_req(up_wr_i, up_rd_i & ~up_wr_i, up_addr_i, up_wdata_i); // [RULE1]
      st_next.up_rd_wait = up_rd_i & ~up_wr_i;
    end else if (st_reg.spi_pend) begin
      req                 = st_reg.spi_req; // [RULE1]
      st_next.spi_pend    = 1'b0;
      st_next.spi_rd_wait = st_reg.spi_req.rd;
    end
    if (req.wr && req.sel == LMTC_SEL_LINE && req.wdata[LMTC_BIT_BPV] && req.wdata[LMTC_BIT_AMI]) begin
      st_next.bpv[req.link] = 1'b1; // [RULE10]
    end
    if (st_reg.up_rd_wait) begin
      st_next.up_rdata  = store_rdata;
      st_next.up_rvalid = 1'b1;
    end
    if (st_reg.spi_rd_wait) begin
      st_next.sdo_sh = store_rdata;
      st_next.sdo_oe = ~spi_cs_n_i;
    end
    if (spi_cs_n_i) begin
      st_next.bit_cnt = 5'h00;
      st_next.sdo_oe  = 1'b0;
    end else if (sclk_rise && st_reg.bit_cnt != LMTC_SPI_ALL_BITS) begin
      st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      if (st_reg.bit_cnt < LMTC_SPI_CMD_BITS) begin
        st_next.cmd_sh = {st_reg.cmd_sh[14:0], spi_sdi_i};
      end else begin
        st_next.data_sh = {st_reg.data_sh[6:0], spi_sdi_i};
      end
      if (st_reg.bit_cnt == LMTC_SPI_CMD_BITS - 5'h01 && st_reg.cmd_sh[LMTC_SPI_READ_BIT-1]) begin
        st_next.spi_pend = 1'b1; // [RULE1]
        st_next.spi_req  = lmtc_make_req(1'b0, 1'b1, st_next.cmd_sh[LMTC_ADDR_W-1:0], 8'h00);
      end
      if (st_reg.bit_cnt == LMTC_SPI_ALL_BITS - 5'h01 && !st_reg.cmd_sh[LMTC_SPI_READ_BIT]) begin
        st_next.spi_pend = 1'b1; // [RULE1]
        st_next.spi_req  = lmtc_make_req(1'b1, 1'b0, st_reg.cmd_sh[LMTC_ADDR_W-1:0],
                                         {st_reg.data_sh[6:0], spi_sdi_i});
      end
    end else if (sclk_fall && st_reg.bit_cnt > LMTC_SPI_CMD_BITS) begin
      st_next.sdo_sh = {st_reg.sdo_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg        <= '0;
      st_reg.cs_n_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  lmtc_cfg_store u_store (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .req_i   (req),
    .rdata_o (store_rdata),
    .regs_o  (regs)
  );

  assign up_rdata_o   = st_reg.up_rdata;
  assign up_rvalid_o  = st_reg.up_rvalid;
  assign spi_sdo_o    = st_reg.sdo_sh[7];
  assign spi_sdo_oe_o = st_reg.sdo_oe;
  assign link_cfg_o   = st_reg.cfg;
  assign bpv_insert_o = st_reg.bpv;

  a_up_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE1]
    up_rd_i && !up_wr_i |-> ##2 up_rvalid_o) else $error("Parallel read not answered in two cycles.");
  a_e1_ignores_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE2]
    !regs[1].mode[LMTC_BIT_CARRIER] |=> link_cfg_o[1].mode == LMTC_MODE_E1) else $error("Link not in E1.");
  a_t1_format_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE3]
    regs[0].mode[3:2] == 2'h2 |=> link_cfg_o[0].mode == LMTC_MODE_T1 && link_cfg_o[0].frame == $past(regs[0].mode[1:0]))
    else $error("T1 format decode wrong.");
  a_j1_format_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE4]
    regs[0].mode[3:1] == 3'h6 |=> link_cfg_o[0].mode == LMTC_MODE_J1 && link_cfg_o[0].frame == $past(regs[0].mode[1:0]))
    else $error("J1 format decode wrong.");
  a_int_match_on: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE5]
    !regs[2].term[LMTC_BIT_TERM_EXT] |=> link_cfg_o[2].int_match) else $error("Internal matching not enabled.");
  a_imp_code_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE6]
    regs[1].term[2:0] == 3'h1 |=> link_cfg_o[1].imp == LMTC_IMP_120) else $error("Impedance code 001 not 120 ohm.");
  a_ext_match_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE7]
    regs[3].term[LMTC_BIT_TERM_EXT] |=> !link_cfg_o[3].int_match && link_cfg_o[3].imp == LMTC_IMP_EXT)
    else $error("External matching not selected.");
  a_rx_hdb3_e1: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE8]
    regs[0].mode[LMTC_BIT_CARRIER] == 1'b0 && !regs[0].line[LMTC_BIT_AMI] |=> link_cfg_o[0].rx_code == LMTC_CODE_HDB3)
    else $error("E1 receive code not HDB3.");
  a_tx_b8zs_t1: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
    regs[0].mode[LMTC_BIT_CARRIER] && !regs[0].line[LMTC_BIT_AMI] |=> link_cfg_o[0].tx_code == LMTC_CODE_B8ZS)
    else $error("T1 transmit code not B8ZS.");
  a_bpv_ami_only: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
    bpv_insert_o[1] |-> $past(req.wr && req.link == 2'h1 && req.sel == LMTC_SEL_LINE && req.wdata[LMTC_BIT_AMI]))
    else $error("Violation inserted without AMI.");
  a_rja_select: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE11]
    $rose(regs[1].line[LMTC_BIT_RJA]) |=> link_cfg_o[1].rja_en) else $error("Jitter attenuator select lost.");
  a_reserved_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE12]
    regs[2].mode[3:1] == 3'h7 |=> link_cfg_o[2].mode == LMTC_MODE_RSVD) else $error("Reserved J1 format not flagged.");
endmodule // lmtc_config_top
`default_nettype wire

// [tb/lmtc_config_top_tb.sv]
// Self-checking testbench of the link mode and termination configuration block.
`timescale 1ns/10ps
`default_nettype none
module lmtc_config_top_tb;
  import lmtc_pkg::*;
  logic                                 clk_i, rst_n_i, up_wr_i, up_rd_i, up_rvalid_o;
  logic                                 spi_sclk_i, spi_cs_n_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o;
  logic [9:0]                           up_addr_i;
  logic [7:0]                           up_wdata_i, up_rdata_o, q;
  logic [LMTC_LINKS-1:0]                bpv_insert_o;
  lmtc_link_cfg_type [LMTC_LINKS-1:0]   link_cfg_o;
  logic [7:0]                           ms[4], ts[4], ls[4];
  int                                   fails, n_tests, cyc, bpv_cnt, b0;

  lmtc_config_top lmtc_config_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .up_addr_i(up_addr_i),
    .up_wdata_i(up_wdata_i), .up_wr_i(up_wr_i), .up_rd_i(up_rd_i), .up_rdata_o(up_rdata_o),
    .up_rvalid_o(up_rvalid_o), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i),
    .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o), .link_cfg_o(link_cfg_o), .bpv_insert_o(bpv_insert_o));
  lmtc_host_model lmtc_host_model_inst (.clk_i(clk_i), .up_addr_o(up_addr_i), .up_wdata_o(up_wdata_i),
    .up_wr_o(up_wr_i), .up_rd_o(up_rd_i), .up_rdata_i(up_rdata_o), .up_rvalid_i(up_rvalid_o),
    .spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .spi_sdi_o(spi_sdi_i), .spi_sdo_i(spi_sdo_o),
    .spi_sdo_oe_i(spi_sdo_oe_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    bpv_cnt <= bpv_cnt + $countones(bpv_insert_o);
    if (cyc == 8000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input lmtc_link_cfg_type got, input lmtc_link_cfg_type exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected decode of one link from its three register values.
  function automatic lmtc_link_cfg_type exp_cfg(input logic [7:0] m, input logic [7:0] t, input logic [7:0] l);
    lmtc_link_cfg_type c;
    c.mode = !m[3] ? LMTC_MODE_E1 : !m[2] ? LMTC_MODE_T1 : m[1] ? LMTC_MODE_RSVD : LMTC_MODE_J1;
    c.frame = (m[3] && !(m[2] && m[1])) ? lmtc_frame_type'(m[1:0]) : LMTC_FRM_SF;
    c.int_match = !t[2];
    c.imp = t[2] ? LMTC_IMP_EXT : lmtc_imp_type'({1'b0, t[1:0]});
    c.rx_code = l[0] ? LMTC_CODE_AMI : m[3] ? LMTC_CODE_B8ZS : LMTC_CODE_HDB3;
    c.tx_code = c.rx_code;
    c.rja_en = l[1];
    c.bpv_ok = l[0];
    return c;
  endfunction

  // Every link is compared, so a write that leaks into another link shows up.
  task automatic chk_all();
    for (int k = 0; k < 4; k++) chk_cfg(link_cfg_o[k], exp_cfg(ms[k], ts[k], ls[k]));
  endtask

  task automatic wr(input logic [1:0] lk, input logic [7:0] ofs, input logic [7:0] d, input logic spi);
    b0 = bpv_cnt;
    if (spi) lmtc_host_model_inst.spi({6'h00, lk, ofs, d}, q);
    else lmtc_host_model_inst.par(1'b1, {lk, ofs}, d, q);
    if (spi) chk8({7'h00, lmtc_host_model_inst.oe_seen}, 8'h00);
    repeat (3) @(posedge clk_i);
    #1;
    if (ofs == LMTC_OFS_MODE) ms[lk] = d & LMTC_MASK_MODE;
    if (ofs == LMTC_OFS_TERM) ts[lk] = d & LMTC_MASK_TERM;
    if (ofs == LMTC_OFS_LINE) ls[lk] = d & LMTC_MASK_LINE;
    chk_all();
  endtask

  task automatic rd(input logic [1:0] lk, input logic [7:0] ofs, input logic [7:0] exp, input logic spi);
    if (spi) lmtc_host_model_inst.spi({6'h20, lk, ofs, 8'h00}, q);
    else lmtc_host_model_inst.par(1'b0, {lk, ofs}, 8'h00, q);
    chk8(q, exp);
    if (spi) chk8({7'h00, lmtc_host_model_inst.oe_seen}, 8'h01);
    if (spi) chk8({7'h00, spi_sdo_oe_o}, 8'h00);
  endtask

  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      rd(k[1:0], LMTC_OFS_MODE, LMTC_RST_MODE, 1'b0);
      rd(k[1:0], LMTC_OFS_TERM, LMTC_RST_TERM, 1'b0);
      rd(k[1:0], LMTC_OFS_LINE, LMTC_RST_LINE, 1'b0);
    end
    chk_all();
  endtask

  task automatic t_mode();
    for (int v = 0; v < 16; v++) begin
      wr(v[1:0], LMTC_OFS_MODE, {4'ha, v[3:0]}, 1'b0);
      rd(v[1:0], LMTC_OFS_MODE, {4'h0, v[3:0]}, 1'b0);
    end
  endtask

  task automatic t_term();
    for (int v = 0; v < 8; v++) begin
      wr(v[1:0], LMTC_OFS_TERM, {5'h1f, v[2:0]}, 1'b0);
      rd(v[1:0], LMTC_OFS_TERM, {5'h00, v[2:0]}, 1'b0);
    end
  endtask

  task automatic t_line();
    for (int v = 0; v < 4; v++) wr(v[1:0], LMTC_OFS_LINE, {6'h00, v[1:0]}, 1'b0);
    wr(2'd1, LMTC_OFS_LINE, 8'h05, 1'b0);
    chk8(8'(bpv_cnt - b0), 8'h01);
    rd(2'd1, LMTC_OFS_LINE, 8'h01, 1'b0);
    wr(2'd1, LMTC_OFS_LINE, 8'h06, 1'b0);
    chk8(8'(bpv_cnt - b0), 8'h00);
  endtask

  task automatic t_spi_unmapped();
    wr(2'd1, LMTC_OFS_MODE, 8'h09, 1'b1);
    rd(2'd1, LMTC_OFS_MODE, 8'h09, 1'b1);
    wr(2'd3, LMTC_OFS_TERM, 8'h04, 1'b1);
    wr(2'd0, 8'h21, 8'hff, 1'b0);
    rd(2'd0, 8'h21, 8'h00, 1'b0);
  endtask

  initial begin
    rst_n_i = 1'b0;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    bpv_cnt = 0;
    for (int k = 0; k < 4; k++) begin
      ms[k] = LMTC_RST_MODE;
      ts[k] = LMTC_RST_TERM;
      ls[k] = LMTC_RST_LINE;
    end
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    t_reset();
    t_mode();
    t_term();
    t_line();
    t_spi_unmapped();
    finish_test();
  end
endmodule // lmtc_config_top_tb
`default_nettype wire

// [tb/lmtc_host_model.sv]
// Host processor model that drives the parallel and SPI configuration ports.
`timescale 1ns/10ps
`default_nettype none
module lmtc_host_model (
  // Clock.
  input  wire logic       clk_i,
  // Parallel port.
  output logic [9:0]      up_addr_o,
  output logic [7:0]      up_wdata_o,
  output logic            up_wr_o,
  output logic            up_rd_o,
  input  wire logic [7:0] up_rdata_i,
  input  wire logic       up_rvalid_i,
  // SPI port.
  output logic            spi_sclk_o,
  output logic            spi_cs_n_o,
  output logic            spi_sdi_o,
  input  wire logic       spi_sdo_i,
  input  wire logic       spi_sdo_oe_i
);
  logic oe_seen;

  initial begin
    up_addr_o = 10'h3ff;
    up_wdata_o = 8'hff;
    up_wr_o = 1'b0;
    up_rd_o = 1'b0;
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdi_o = 1'b1;
  end

  // One-cycle parallel access; released lines show the inverse of the last value.
  task automatic par(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    q = 8'hxx;
    @(posedge clk_i);
    #1;
    up_addr_o = a;
    up_wdata_o = d;
    up_wr_o = wr;
    up_rd_o = !wr;
    @(posedge clk_i);
    #1;
    up_wr_o = 1'b0;
    up_rd_o = 1'b0;
    up_addr_o = ~a;
    up_wdata_o = ~d;
    for (n = 0; n < 4 && !wr; n++) begin
      if (up_rvalid_i === 1'b1) begin
        q = up_rdata_i;
        break;
      end
      @(posedge clk_i);
      #1;
    end
  endtask

  // One 24-bit SPI frame, MSB first; the clock stands low outside the frame.
  task automatic spi(input logic [23:0] f, output logic [7:0] q);
    int i;
    q = 8'h00;
    @(posedge clk_i);
    #1;
    spi_cs_n_o = 1'b0;
    for (i = 23; i >= 0; i--) begin
      spi_sdi_o = f[i];
      repeat (4) @(posedge clk_i);
      #1;
      spi_sclk_o = 1'b1;
      if (i < 8) q[i] = spi_sdo_i;
      if (i == 0) oe_seen = spi_sdo_oe_i;
      repeat (4) @(posedge clk_i);
      #1;
      spi_sclk_o = 1'b0;
    end
    repeat (4) @(posedge clk_i);
    #1;
    spi_cs_n_o = 1'b1;
    spi_sdi_o = ~f[0];
    repeat (4) @(posedge clk_i);
  endtask
endmodule // lmtc_host_model
`default_nettype wire
